/* src/smr_cal_engine.sv */
// Impedance calibration engine: times one calibration and updates the setting.
// Assumes a resistor-present strap and a measured target from the analog side.
`default_nettype none
module smr_cal_engine
   import smr_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic resistorPresent,
   input wire logic [7:0] impTarget,
   smr_cmd_if.eng cmd
);
   logic [15:0] calCnt_ff;
   logic [7:0] calCode_ff;
   logic [7:0] impSetting_ff;
   logic calBusy_ff;
   logic calDone_ff;

   assign cmd.calBusy = calBusy_ff;
   assign cmd.calDone = calDone_ff;
   assign cmd.impSetting = impSetting_ff;

   // ******************************
   // Sequencing
   // ******************************
   // Starts a calibration only when a resistor is fitted and the code is valid.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         calBusy_ff <= 1'b0;
         calDone_ff <= 1'b0;
         calCnt_ff <= 16'h0000;
         calCode_ff <= 8'h00;
      end else if (clkEn) begin
         calDone_ff <= 1'b0;
         if (cmd.calStart && !calBusy_ff && resistorPresent) begin
            calCode_ff <= cmd.calCode;
            calBusy_ff <= 1'b1;
            case (cmd.calCode)
               CodeCalInit: calCnt_ff <= 16'(CalInitCycles);
               CodeCalLong: calCnt_ff <= 16'(CalLongCycles);
               CodeCalShort: calCnt_ff <= 16'(CalShortCycles);
               CodeCalReset: calCnt_ff <= 16'(CalResetCycles);
               default: calBusy_ff <= 1'b0;
            endcase
         end else if (calBusy_ff) begin
            if (calCnt_ff <= 16'h0001) begin
               calBusy_ff <= 1'b0; // Pin circuitry powered down here.
               calDone_ff <= 1'b1;
            end else begin
               calCnt_ff <= calCnt_ff - 16'h0001;
            end
         end
      end
   end

   // Applies the result: full/long converge, short steps, reset restores.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         impSetting_ff <= ImpDefault;
      end else if (clkEn && calBusy_ff && calCnt_ff <= 16'h0001) begin
         case (calCode_ff)
            CodeCalInit, CodeCalLong: impSetting_ff <= impTarget;
            CodeCalReset: impSetting_ff <= ImpDefault;
            CodeCalShort: begin // One step per short calibration.
               if (impSetting_ff < impTarget) begin
                  impSetting_ff <= impSetting_ff + 8'h01;
               end else if (impSetting_ff > impTarget) begin
                  impSetting_ff <= impSetting_ff - 8'h01;
               end
            end
            default: impSetting_ff <= impSetting_ff;
         endcase
      end
   end
endmodule
`default_nettype wire

/* src/smr_cmd_if.sv */
// Interface carrying a decoded mode-register command to the calibration engine.
// Assumes both ends share clk_sys.
`default_nettype none
interface smr_cmd_if;
   logic calStart;
   logic [7:0] calCode;
   logic calBusy;
   logic calDone;
   logic [7:0] impSetting;
   modport ctrl (output calStart, output calCode, input calBusy, input calDone,
      input impSetting);
   modport eng (input calStart, input calCode, output calBusy, output calDone,
      output impSetting);
endinterface
`default_nettype wire

/* src/smr_mode_regs.sv */
// Mode-register command decode, temperature status, calibration patterns.
// Assumes CA bits are presented as rising and falling halves, synchronous to clk_sys.
// Contract
// - Temperature status refreshed at least every 32 ms update interval.
// - Pattern A reads 1,0,1,0; pattern B reads 0,0,1,1.
// - Pattern driven on lowest line of every byte lane.
// - All other lines of each lane copy line 0 during the burst.
// - Write decoded when select low and CA0..CA3 low on rising edge.
// - Address from falling CA1-0 and rising CA9-4; data from falling CA9-2.
// - Writes to read-only registers are ignored.
// - Reads accepted with banks active; banks stay active.
// - Reset write restores defaults and enters auto-initialization.
// - Four calibration operations chosen by code written to address 0Ah.
// - Init and long reach 15 percent; reset restores 30 percent default.
// - Each short calibration corrects at least 1.5 percent error.
// - Calibration pin circuitry disabled once calibration finishes.
// - Read decoded when select low, CA0..CA2 low, CA3 high.
// - Reads burst four beats and are not interrupted.
// - Without a resistor, calibration commands are ignored, defaults kept.
`default_nettype none
module smr_mode_regs
   import smr_pkg::*;
#(
   parameter int DataWidth = 32,
   parameter int TempCycles = TempUpdateCycles
)(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic chipSel_n,
   input wire logic [9:0] caRise,
   input wire logic [9:0] caFall,
   input wire logic [2:0] tempSensor,
   input wire logic resistorPresent,
   input wire logic [7:0] impTarget,
   input wire logic anyBankActive,
   output logic [DataWidth-1:0] dqOut,
   output logic dqOutEn,
   output logic dqsToggle,
   output logic [2:0] tempStatus,
   output logic [7:0] impSetting,
   output logic calBusy,
   output logic devBusy,
   output logic autoInitActive,
   output logic arrayUndefined
);
   localparam int Lanes = DataWidth / 8;

   smr_state_t state_ff;
   logic [31:0] tempCnt_ff;
   logic [2:0] tempStatus_ff;
   logic [7:0] impCalReg_ff;
   logic [15:0] waitCnt_ff;
   logic [1:0] beat_ff;
   logic [7:0] rdAddr_ff;
   logic [DataWidth-1:0] dqOut_ff;
   logic dqOutEn_ff;
   logic dqsToggle_ff;
   logic arrayUndef_ff;
   logic isWrite;
   logic isRead;
   logic [7:0] cmdAddr;
   logic [7:0] cmdData;
   logic [3:0] pattern;
   logic [7:0] beatByte;

   smr_cmd_if calIf ();

   smr_cal_engine uCal (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .clkEn(clkEn),
      .resistorPresent(resistorPresent),
      .impTarget(impTarget),
      .cmd(calIf.eng)
   );

   // ******************************
   // Command decode
   // ******************************
   // Decodes the command on the rising half and gathers address and data.
   assign isWrite = !chipSel_n && caRise[3:0] == 4'h0;
   assign isRead = !chipSel_n && caRise[3:0] == 4'h8;
   assign cmdAddr = {caRise[9:4], caFall[1:0]};
   assign cmdData = caFall[9:2];
   // A write refused for an open bank must not start the engine either.
   assign calIf.calStart = clkEn && state_ff == SmrIdle && isWrite && !anyBankActive
      && cmdAddr == AddrImpedanceCal;
   assign calIf.calCode = cmdData;

   // ******************************
   // Temperature status
   // ******************************
   // Samples the sensor each update interval so status never ages past it.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tempCnt_ff <= 32'h00000000;
         tempStatus_ff <= TempReset;
      end else if (clkEn) begin
         if (tempCnt_ff >= 32'(TempCycles - 1)) begin
            tempCnt_ff <= 32'h00000000;
            tempStatus_ff <= tempSensor;
         end else begin
            tempCnt_ff <= tempCnt_ff + 32'h00000001;
         end
      end
   end

   // ******************************
   // Writable register and state
   // ******************************
   // Main sequencer: write period, auto-init, calibration and read bursts.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= SmrIdle;
         waitCnt_ff <= 16'h0000;
         impCalReg_ff <= ImpCalRegReset;
         rdAddr_ff <= 8'h00;
         arrayUndef_ff <= 1'b0;
      end else if (clkEn) begin
         case (state_ff)
            SmrIdle: begin
               if (isRead) begin // Accepted even with banks active.
                  rdAddr_ff <= cmdAddr;
                  state_ff <= SmrRead;
               end else if (isWrite && !anyBankActive) begin
                  if (cmdAddr == AddrReset) begin
                     impCalReg_ff <= ImpCalRegReset;
                     arrayUndef_ff <= 1'b1;
                     waitCnt_ff <= 16'(AutoInitCycles);
                     state_ff <= SmrAutoInit;
                  end else if (cmdAddr == AddrImpedanceCal) begin
                     impCalReg_ff <= cmdData;
                     state_ff <= SmrCal;
                  end else begin
                     // Read-only and unknown targets change no register; only the write period runs.
                     waitCnt_ff <= 16'(ModeWriteCycles);
                     state_ff <= SmrModeWrite;
                  end
               end
            end
            SmrModeWrite, SmrAutoInit: begin
               if (waitCnt_ff <= 16'h0001) begin
                  state_ff <= SmrIdle;
               end else begin
                  waitCnt_ff <= waitCnt_ff - 16'h0001;
               end
            end
            SmrCal: begin
               // Engine refused or finished: return to idle.
               if (!calIf.calBusy) begin
                  state_ff <= SmrIdle;
               end
            end
            SmrRead: begin
               if (beat_ff == 2'(ReadBurstLen - 1)) begin
                  state_ff <= SmrIdle;
               end
            end
            default: state_ff <= SmrIdle;
         endcase
      end
   end

   // ******************************
   // Read data path
   // ******************************
   // Selects the calibration pattern or register byte for the current beat.
   always_comb begin
      pattern = 4'h0;
      beatByte = 8'h00;
      if (rdAddr_ff == AddrCalPatternA) begin
         pattern = PatternA;
      end else if (rdAddr_ff == AddrCalPatternB) begin
         pattern = PatternB;
      end
      if (rdAddr_ff == AddrCalPatternA || rdAddr_ff == AddrCalPatternB) begin
         beatByte = {8{pattern[3 - beat_ff]}};
      end else if (beat_ff == 2'h0) begin
         if (rdAddr_ff == AddrTempStatus) begin
            beatByte = {5'h00, tempStatus_ff};
         end else if (rdAddr_ff == AddrImpedanceCal) begin
            beatByte = impCalReg_ff;
         end
      end
   end

   // Drives the burst: beat counter, data on every lane, strobe toggle.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         beat_ff <= 2'h0;
         dqOut_ff <= '0;
         dqOutEn_ff <= 1'b0;
         dqsToggle_ff <= 1'b0;
      end else if (clkEn) begin
         if (state_ff == SmrRead) begin
            beat_ff <= beat_ff + 2'h1;
            dqOut_ff <= {Lanes{beatByte}};
            dqOutEn_ff <= 1'b1;
            dqsToggle_ff <= ~dqsToggle_ff;
         end else begin
            beat_ff <= 2'h0;
            dqOut_ff <= '0;
            dqOutEn_ff <= 1'b0;
            dqsToggle_ff <= 1'b0;
         end
      end
   end

   // ******************************
   // Registered outputs
   // ******************************
   // Mirrors internal state onto outputs through flip-flops.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tempStatus <= TempReset;
         impSetting <= ImpDefault;
         calBusy <= 1'b0;
         devBusy <= 1'b0;
         autoInitActive <= 1'b0;
         arrayUndefined <= 1'b0;
      end else if (clkEn) begin
         tempStatus <= tempStatus_ff;
         impSetting <= calIf.impSetting;
         calBusy <= calIf.calBusy;
         devBusy <= state_ff != SmrIdle;
         autoInitActive <= state_ff == SmrAutoInit;
         arrayUndefined <= arrayUndef_ff;
      end
   end

   assign dqOut = dqOut_ff;
   assign dqOutEn = dqOutEn_ff;
   assign dqsToggle = dqsToggle_ff;
endmodule
`default_nettype wire

/* src/smr_pkg.sv */
// Package for the mode-register, calibration and temperature block.
// Assumes a single 40 MHz system clock; command/address bits arrive pre-captured.
`default_nettype none
package smr_pkg;
   // ******************************
   // Clock and timing
   // ******************************
   localparam int ClkMhz = 40;
   localparam int TempUpdateMs = 32;
   localparam int TempUpdateCycles = TempUpdateMs * 1000 * ClkMhz;
   localparam int ModeWriteNs = 125;
   localparam int ModeWriteCycles = (ModeWriteNs * ClkMhz + 999) / 1000;
   localparam int AutoInitUs = 1;
   localparam int AutoInitCycles = (AutoInitUs * 1000 * ClkMhz + 999) / 1000;
   localparam int CalInitUs = 1;
   localparam int CalInitCycles = (CalInitUs * ClkMhz * 1000 + 999) / 1000;
   localparam int CalLongNs = 360;
   localparam int CalLongCycles = (CalLongNs * ClkMhz + 999) / 1000;
   localparam int CalShortNs = 90;
   localparam int CalShortCycles = (CalShortNs * ClkMhz + 999) / 1000;
   localparam int CalResetNs = 50;
   localparam int CalResetCycles = (CalResetNs * ClkMhz + 999) / 1000;
   localparam int ReadBurstLen = 4;
   // ******************************
   // Mode register addresses
   // ******************************
   localparam logic [7:0] AddrTempStatus = 8'h04;
   localparam logic [7:0] AddrImpedanceCal = 8'h0a;
   localparam logic [7:0] AddrCalPatternA = 8'h20;
   localparam logic [7:0] AddrCalPatternB = 8'h28;
   localparam logic [7:0] AddrReset = 8'h3f;
   localparam logic [3:0] PatternA = 4'ha; // Bit time 0 is the top bit.
   localparam logic [3:0] PatternB = 4'h3; // Bit time 0 is the top bit.
   // ******************************
   // Calibration command codes and defaults
   // ******************************
   localparam logic [7:0] CodeCalInit = 8'hff;
   localparam logic [7:0] CodeCalLong = 8'hab;
   localparam logic [7:0] CodeCalShort = 8'h56;
   localparam logic [7:0] CodeCalReset = 8'hc3;
   localparam logic [7:0] ImpDefault = 8'h80;
   localparam logic [2:0] TempReset = 3'h3;
   localparam logic [7:0] ImpCalRegReset = 8'h00;
   typedef enum logic [2:0] {
      SmrIdle = 3'b000,
      SmrModeWrite = 3'b001,
      SmrAutoInit = 3'b010,
      SmrCal = 3'b011,
      SmrRead = 3'b100
   } smr_state_t;
endpackage
`default_nettype wire

/* verification/smr_ctrl_model.sv */
// Memory controller model issuing one mode-register command per request.
// Assumes the bench holds req until ack is seen high.
`default_nettype none
module smr_ctrl_model (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic req,
   input wire logic reqWr,
   input wire logic [7:0] reqAddr,
   input wire logic [7:0] reqData,
   input wire logic devBusy,
   input wire logic dqOutEn,
   input wire logic calBusy,
   output logic ack,
   output logic chipSel_n,
   output logic [9:0] caRise,
   output logic [9:0] caFall
);
   // ****************************************
   // Command issue
   // ****************************************
   logic [2:0] idleCnt_ff;
   // Counts quiet cycles so a command waits out the busy lag.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         idleCnt_ff <= 3'h0;
      end else if (devBusy || dqOutEn || calBusy || !chipSel_n) begin
         idleCnt_ff <= 3'h0;
      end else if (idleCnt_ff != 3'h7) begin
         idleCnt_ff <= idleCnt_ff + 3'h1;
      end
   end
   // One device, never the data lines, so the bus is quiet while calibrating.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ack <= 1'b0;
         chipSel_n <= 1'b1;
         caRise <= 10'h155;
         caFall <= 10'h2aa;
      end else if (req && !ack && idleCnt_ff == 3'h7) begin
         ack <= 1'b1;
         chipSel_n <= 1'b0;
         caRise <= {reqAddr[7:2], reqWr ? 4'h0 : 4'h8}; // Opcode and address.
         caFall <= {reqData, reqAddr[1:0]}; // Data and low address.
      end else begin
         ack <= 1'b0;
         chipSel_n <= 1'b1;
         caRise <= ~caRise;
         caFall <= ~caFall;
      end
   end
endmodule
`default_nettype wire

/* verification/smr_mode_regs_chk.sv */
// Checker for the mode-register block, watching the top module's ports only.
// Assumes one clk_sys domain; it is bound to every instance at the foot.
`default_nettype none
module smr_mode_regs_chk
   import smr_pkg::*;
#(
   parameter int DataWidth = 32,
   parameter int TempCycles = TempUpdateCycles
)(
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic clkEn,
   input wire logic chipSel_n,
   input wire logic [9:0] caRise,
   input wire logic [9:0] caFall,
   input wire logic [2:0] tempSensor,
   input wire logic resistorPresent,
   input wire logic [7:0] impTarget,
   input wire logic anyBankActive,
   input wire logic [DataWidth-1:0] dqOut,
   input wire logic dqOutEn,
   input wire logic dqsToggle,
   input wire logic [2:0] tempStatus,
   input wire logic [7:0] impSetting,
   input wire logic calBusy,
   input wire logic devBusy,
   input wire logic autoInitActive,
   input wire logic arrayUndefined
);
   // ****************************************
   // Helper logic and properties
   // ****************************************
   logic rdCmd, wrCmd, quiet, idleNow, calRd_ff, plainWr_ff;
   logic [7:0] cmdAddr;
   logic [1:0] quietCnt_ff;
   logic [2:0] lastSensor_ff;
   int tempAge_ff;
   // Commands decode from select and the rising half of the bus.
   assign rdCmd = clkEn && !chipSel_n && caRise[3:0] == 4'h8;
   assign wrCmd = clkEn && !chipSel_n && caRise[3:0] == 4'h0;
   assign cmdAddr = {caRise[9:4], caFall[1:0]};
   assign quiet = !devBusy && !dqOutEn && !calBusy && !autoInitActive;
   assign idleNow = quiet && quietCnt_ff == 2'h3;
   // Quiet cycles are counted so that the busy lag never looks idle.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         quietCnt_ff <= 2'h0;
         calRd_ff <= 1'b0;
         plainWr_ff <= 1'b0;
      end else begin
         if (!quiet || rdCmd || wrCmd) begin
            quietCnt_ff <= 2'h0;
         end else if (quietCnt_ff != 2'h3) begin
            quietCnt_ff <= quietCnt_ff + 2'h1;
         end
         if ((rdCmd || wrCmd) && idleNow) begin
            calRd_ff <= rdCmd && (cmdAddr == AddrCalPatternA || cmdAddr == AddrCalPatternB);
            plainWr_ff <= wrCmd && !anyBankActive && cmdAddr != AddrImpedanceCal
               && cmdAddr != AddrReset;
         end
      end
   end
   // The age of the status counts while it disagrees with a steady sensor, frozen with clkEn.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         lastSensor_ff <= 3'h0;
         tempAge_ff <= 0;
      end else if (clkEn) begin
         lastSensor_ff <= tempSensor;
         tempAge_ff <= (tempStatus == tempSensor || tempSensor != lastSensor_ff) ? 0
            : tempAge_ff + 1;
      end
   end
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   a_read_start: assert property (rdCmd && idleNow |-> ##[2:3] $rose(dqOutEn))
      else $error("read command gave no burst");
   a_burst_four: assert property ($rose(dqOutEn) |-> dqOutEn [*4] ##1 !dqOutEn)
      else $error("read burst is not four beats long");
   a_lane_copy: assert property (dqOutEn && calRd_ff |-> dqOut == {DataWidth{dqOut[0]}})
      else $error("calibration beat differs between data lines");
   a_strobe_beat: assert property (dqOutEn |-> dqsToggle != $past(dqsToggle))
      else $error("strobe did not toggle on a beat");
   a_write_busy: assert property (wrCmd && idleNow && !anyBankActive |-> ##[2:3] devBusy)
      else $error("write command was not taken");
   a_write_period: assert property ($rose(devBusy) && plainWr_ff |-> devBusy [*5] ##1 !devBusy)
      else $error("plain write period is not five cycles");
   a_reset_init: assert property (wrCmd && idleNow && !anyBankActive
      && cmdAddr == AddrReset |-> ##[2:3] autoInitActive)
      else $error("reset write did not start auto-initialization");
   a_array_lost: assert property ($fell(autoInitActive) |-> arrayUndefined)
      else $error("array not marked undefined after reset write");
   a_cal_bound: assert property ($rose(calBusy) |-> ##[1:60] !calBusy)
      else $error("calibration did not finish in time");
   a_no_resistor: assert property (!resistorPresent |-> $stable(impSetting))
      else $error("impedance moved with no resistor fitted");
   a_temp_fresh: assert property (tempAge_ff <= TempCycles + 4)
      else $error("temperature status is stale");
   c_bank_read: cover property (rdCmd && idleNow && anyBankActive);
   c_auto_init: cover property ($fell(autoInitActive));
   c_cal_run: cover property ($rose(calBusy));
endmodule
bind smr_mode_regs smr_mode_regs_chk #(.DataWidth(DataWidth), .TempCycles(TempCycles)) u_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .chipSel_n(chipSel_n),
   .caRise(caRise), .caFall(caFall), .tempSensor(tempSensor),
   .resistorPresent(resistorPresent), .impTarget(impTarget), .anyBankActive(anyBankActive),
   .dqOut(dqOut), .dqOutEn(dqOutEn), .dqsToggle(dqsToggle), .tempStatus(tempStatus),
   .impSetting(impSetting), .calBusy(calBusy), .devBusy(devBusy),
   .autoInitActive(autoInitActive), .arrayUndefined(arrayUndefined));
`default_nettype wire

/* verification/smr_mode_regs_test.sv */
// Self-checking bench for the mode-register block driven by a controller model.
// Assumes the package, design, checker and model are compiled before it.
`default_nettype none
module smr_mode_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   import smr_pkg::*;
   // ****************************************
   // Stimulus and checks
   // ****************************************
   localparam int TempCyc = 50;
   typedef struct packed {
      logic wr;
      logic bank;
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] expImp;
      logic [3:0] expPat;
   } smr_row_t;
   // Bit time 0 of a pattern sits in the top bit of expPat.
   localparam smr_row_t Rows [8] = '{
      '{1'b1, 1'b0, 8'h0a, 8'hff, 8'h90, 4'h0}, '{1'b1, 1'b0, 8'h0a, 8'hc3, 8'h80, 4'h0},
      '{1'b1, 1'b0, 8'h0a, 8'h56, 8'h81, 4'h0}, '{1'b1, 1'b0, 8'h0a, 8'hab, 8'h90, 4'h0},
      '{1'b0, 1'b0, 8'h20, 8'h00, 8'h90, 4'ha}, '{1'b0, 1'b1, 8'h04, 8'h00, 8'h90, 4'h0},
      '{1'b1, 1'b0, 8'h28, 8'h12, 8'h90, 4'h0}, '{1'b0, 1'b0, 8'h28, 8'h00, 8'h90, 4'h3}};
   logic clk_sys, reset_n, clkEn, chipSel_n, resistorPresent, anyBankActive;
   logic dqOutEn, dqsToggle, calBusy, devBusy, autoInitActive, arrayUndefined;
   logic req, reqWr, ack;
   logic [9:0] caRise, caFall;
   logic [2:0] tempSensor, tempStatus;
   logic [7:0] impTarget, impSetting, reqAddr, reqData;
   logic [31:0] dqOut;
   int n_fail, cmp_count, beats;
   smr_mode_regs #(.DataWidth(32), .TempCycles(TempCyc)) u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .chipSel_n(chipSel_n),
      .caRise(caRise), .caFall(caFall), .tempSensor(tempSensor),
      .resistorPresent(resistorPresent), .impTarget(impTarget), .anyBankActive(anyBankActive),
      .dqOut(dqOut), .dqOutEn(dqOutEn), .dqsToggle(dqsToggle), .tempStatus(tempStatus),
      .impSetting(impSetting), .calBusy(calBusy), .devBusy(devBusy),
      .autoInitActive(autoInitActive), .arrayUndefined(arrayUndefined));
   smr_ctrl_model u_ctrl (
      .clk_sys(clk_sys), .reset_n(reset_n), .req(req), .reqWr(reqWr), .reqAddr(reqAddr),
      .reqData(reqData), .devBusy(devBusy), .dqOutEn(dqOutEn), .calBusy(calBusy),
      .ack(ack), .chipSel_n(chipSel_n), .caRise(caRise), .caFall(caFall));
   // The clock inverts every 12.5 ns, half of its 25 ns period.
   always #12.5 clk_sys = ~clk_sys;
   task automatic step();
      @(posedge clk_sys);
      #2;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic give_up(input string what);
      n_fail++;
      $display("[FAIL] %s expected completion seen timeout", what);
      tally_and_finish();
   endtask
   // Hands one command to the model and follows it to the end, checking beats.
   task automatic run_cmd(input smr_row_t r);
      int i;
      beats = 0;
      reqWr = r.wr;
      reqAddr = r.addr;
      reqData = r.data;
      anyBankActive = r.bank;
      req = 1'b1;
      for (i = 0; i < 100 && ack !== 1'b1; i++) begin
         step();
      end
      if (ack !== 1'b1) begin
         give_up("command accept");
      end
      req = 1'b0;
      for (i = 0; i < 200; i++) begin
         step();
         if (dqOutEn === 1'b1) begin
            check("strobe", 32'(dqsToggle), beats[0] ? 32'h0 : 32'h1); // Toggle.
            if (r.addr != AddrTempStatus) begin
               check("pattern beat", dqOut, {32{r.expPat[3 - beats]}}); // Beat.
            end else if (beats == 0) begin
               check("temperature read", 32'(dqOut[2:0]), 32'(tempSensor)); // Status.
            end
            beats++;
         end else if (i > 8 && devBusy === 1'b0 && calBusy === 1'b0) begin
            break;
         end
      end
      if (i == 200) begin
         give_up("command end");
      end
   endtask
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      clkEn = 1'b1;
      tempSensor = 3'h6;
      resistorPresent = 1'b1;
      impTarget = 8'h90;
      anyBankActive = 1'b0;
      req = 1'b0;
      reqWr = 1'b0;
      reqAddr = 8'h00;
      reqData = 8'h00;
      n_fail = 0;
      cmp_count = 0;
      repeat (3) step();
      check("reset status", 32'(tempStatus), 32'(TempReset)); // Defaults.
      check("reset impedance", 32'(impSetting), 32'(ImpDefault)); // Defaults.
      check("reset flags", 32'({dqOutEn, dqsToggle, calBusy, devBusy, autoInitActive,
         arrayUndefined}), 32'h0); // Idle.
      step();
      reset_n = 1'b1;
      // The initial calibration comes first, as every device needs it.
      foreach (Rows[k]) begin
         run_cmd(Rows[k]);
         check("impedance", 32'(impSetting), 32'(Rows[k].expImp)); // Set.
         check("beat count", beats, Rows[k].wr ? 32'h0 : 32'h4); // Burst.
      end
      // The status is checked TempCyc + 4 cycles after the sensor changes, past one update interval.
      tempSensor = 3'h2;
      repeat (TempCyc + 4) step();
      check("temperature status", 32'(tempStatus), 32'h2); // Fresh.
      // A low clock enable freezes the status, which resumes once enabled again.
      clkEn = 1'b0;
      tempSensor = 3'h5;
      repeat (TempCyc + 4) step();
      check("frozen status", 32'(tempStatus), 32'h2); // Held.
      clkEn = 1'b1;
      repeat (TempCyc + 4) step();
      check("resumed status", 32'(tempStatus), 32'h5); // Fresh.
      // Writes with a bank open or no resistor leave the setting alone.
      impTarget = 8'h70;
      run_cmd(smr_row_t'{1'b1, 1'b1, 8'h0a, 8'hab, 8'h00, 4'h0});
      check("bank open write", 32'(impSetting), 32'h90); // Refused.
      resistorPresent = 1'b0;
      run_cmd(smr_row_t'{1'b1, 1'b0, 8'h0a, 8'hff, 8'h00, 4'h0});
      check("no resistor", 32'(impSetting), 32'h90); // Kept.
      resistorPresent = 1'b1;
      // A reset write runs auto-initialization and leaves the array undefined.
      run_cmd(smr_row_t'{1'b1, 1'b0, 8'h3f, 8'h00, 8'h00, 4'h0});
      check("after reset write", 32'({arrayUndefined, autoInitActive}), 32'h2); // Done.
      tally_and_finish();
   end
endmodule
`default_nettype wire
